// ### logic/sem_regs.sv
// Duplicated mode registers selected by frequency set point
`timescale 1ns/1ps
`default_nettype none
`include "sem_map.svh"

module sem_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Link pins
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic cs_pin,
  input wire logic mrw_pin,
  input wire logic mrr_pin,
  input wire logic [5:0] ma_pin,
  input wire logic [7:0] op_pin,
  input wire logic cbt_pin,
  // Register read answer
  output logic [7:0] mrr_data,
  output logic mrr_valid,
  // Configuration in force
  output sem_pkg::sem_cfg_t active_cfg,
  output sem_pkg::sem_ctrl_t ctrl,
  output logic ck_ref_is_ca,
  output logic dqs_ref_is_dq,
  output logic [5:0] cbt_ignore_mask,
  // Status
  output logic cmd_ready,
  output logic early_cmd_err,
  output logic post_clk_err
);
  localparam logic [3:0] SETTLE_REF_CYC = 4'((`SEM_SETTLE_TIME_PS +
    `SEM_REF_PERIOD_PS - 1) / `SEM_REF_PERIOD_PS);

  logic [19:0] pins_s;
  logic ck_s, cke_s, cs_s, cbt_s;
  sem_pkg::sem_cmd_t cmd;

  sem_sync #(.WIDTH(20)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .async_in({ck_pin, cke_pin, cs_pin, mrw_pin, mrr_pin, ma_pin, op_pin,
      cbt_pin}),
    .sync_out(pins_s)
  );

  assign ck_s = pins_s[19];
  assign cke_s = pins_s[18];
  assign cs_s = pins_s[17];
  assign cbt_s = pins_s[0];

  // State
  sem_pkg::sem_cfg_t copy_q [2];
  sem_pkg::sem_cfg_t copy_d [2];
  sem_pkg::sem_ctrl_t ctrl_q, ctrl_d;
  sem_pkg::sem_cfg_t act_q, act_d;
  sem_pkg::sem_state_t state_q, state_d;
  logic ck_prev_q, ck_prev_d;
  logic [3:0] nck_q, nck_d;
  logic [3:0] ref_q, ref_d;
  logic [1:0] post_q, post_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic early_q, early_d;
  logic post_err_q, post_err_d;
  logic ckref_q, ckref_d;
  logic dqsref_q, dqsref_d;
  logic [5:0] ign_q, ign_d;

  logic ck_rise;
  logic take;
  logic ws;
  logic [7:0] wsel;
  logic [7:0] rsel;
  logic op_new;
  logic mode_change;

  assign ck_rise = ck_s & ~ck_prev_q;
  assign take = ck_rise & cke_s & cs_s;
  assign cmd = sem_pkg::sem_cmd_t'({pins_s[16], pins_s[15], pins_s[14:9],
    pins_s[8:1]});

  // Copy picked by the write selector, for writes and reads
  assign ws = ctrl_q.write_set_point_sel;
  always_comb begin
    op_new = cmd.op[`SEM_BIT_OPERATING_SET_POINT];
    wsel = 8'h00;
    rsel = 8'h00;
    case (cmd.addr)
      `SEM_MA_PREAMBLE_RECOVERY: begin
        wsel = `SEM_WMASK_PREAMBLE_RECOVERY;
        rsel = copy_q[ws].preamble_recovery_cfg;
      end
      `SEM_MA_LATENCY: begin
        wsel = `SEM_WMASK_LATENCY;
        rsel = copy_q[ws].latency_cfg;
      end
      `SEM_MA_DRIVE_INVERSION: begin
        wsel = `SEM_WMASK_DRIVE_INVERSION;
        rsel = copy_q[ws].drive_inversion_cfg;
      end
      `SEM_MA_TERMINATION: begin
        wsel = `SEM_WMASK_TERMINATION;
        rsel = copy_q[ws].termination_cfg;
      end
      `SEM_MA_COMMAND_REFERENCE: begin
        wsel = `SEM_WMASK_COMMAND_REFERENCE;
        rsel = copy_q[ws].command_reference_cfg;
      end
      `SEM_MA_DATA_REFERENCE: begin
        wsel = `SEM_WMASK_DATA_REFERENCE;
        rsel = copy_q[ws].data_reference_cfg;
      end
      `SEM_MA_LOW_SPEED_BUFFER: begin
        wsel = `SEM_WMASK_LOW_SPEED_BUFFER;
        rsel = copy_q[ws].low_speed_buffer_cfg;
      end
      `SEM_MA_CONTROLLER_TERM: begin
        wsel = `SEM_WMASK_CONTROLLER_TERM;
        rsel = copy_q[ws].controller_termination_cfg;
      end
      `SEM_MA_SINGLE_ENDED_SEL: begin
        wsel = `SEM_WMASK_SINGLE_ENDED_SEL;
        rsel = copy_q[ws].single_ended_select_cfg;
      end
      `SEM_MA_SET_POINT_CTRL: begin
        rsel = 8'h00;
        rsel[`SEM_BIT_FAST_RESPONSE] = ctrl_q.reference_fast_response;
        rsel[`SEM_BIT_WRITE_SET_POINT] = ctrl_q.write_set_point_sel;
        rsel[`SEM_BIT_OPERATING_SET_POINT] = ctrl_q.operating_set_point_sel;
      end
      default: begin
        wsel = 8'h00;
        rsel = 8'h00;
      end
    endcase
    mode_change = (copy_q[op_new].single_ended_select_cfg[
      `SEM_BIT_SINGLE_CLOCK:`SEM_BIT_SINGLE_WRITE_STROBE] !=
      act_q.single_ended_select_cfg[
      `SEM_BIT_SINGLE_CLOCK:`SEM_BIT_SINGLE_WRITE_STROBE]);
  end

  // Register writes, reads and set-point switching
  always_comb begin
    logic [7:0] merged;
    merged = 8'h00;
    copy_d = copy_q;
    ctrl_d = ctrl_q;
    act_d = copy_q[ctrl_q.operating_set_point_sel];
    ck_prev_d = ck_s;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    early_d = early_q;
    state_d = state_q;
    nck_d = nck_q;
    ref_d = ref_q;
    post_d = post_q;
    post_err_d = post_err_q;
    if (take && state_q == sem_pkg::SEM_SETTLE) begin
      early_d = 1'b1; // Command before link clock settled; dropped
    end else if (take && cmd.wr) begin
      post_d = `SEM_POST_WRITE_NCK;
      if (cmd.addr == `SEM_MA_SET_POINT_CTRL) begin
        ctrl_d.reference_fast_response = cmd.op[`SEM_BIT_FAST_RESPONSE];
        ctrl_d.write_set_point_sel = cmd.op[`SEM_BIT_WRITE_SET_POINT];
        ctrl_d.operating_set_point_sel = op_new;
        if (op_new != ctrl_q.operating_set_point_sel && mode_change) begin
          state_d = sem_pkg::SEM_SETTLE;
          nck_d = 4'h0;
          ref_d = 4'h0;
        end
      end else begin
        merged = (rsel & ~wsel) | (cmd.op & wsel);
        case (cmd.addr)
          `SEM_MA_PREAMBLE_RECOVERY: copy_d[ws].preamble_recovery_cfg = merged;
          `SEM_MA_LATENCY: copy_d[ws].latency_cfg = merged;
          `SEM_MA_DRIVE_INVERSION: copy_d[ws].drive_inversion_cfg = merged;
          `SEM_MA_TERMINATION: copy_d[ws].termination_cfg = merged;
          `SEM_MA_COMMAND_REFERENCE: copy_d[ws].command_reference_cfg = merged;
          `SEM_MA_DATA_REFERENCE: copy_d[ws].data_reference_cfg = merged;
          `SEM_MA_LOW_SPEED_BUFFER: copy_d[ws].low_speed_buffer_cfg = merged;
          `SEM_MA_CONTROLLER_TERM:
            copy_d[ws].controller_termination_cfg = merged;
          `SEM_MA_SINGLE_ENDED_SEL:
            copy_d[ws].single_ended_select_cfg = merged;
          default: merged = 8'h00;
        endcase
      end
    end else if (take && cmd.rd) begin
      rdata_d = rsel;
      rvalid_d = 1'b1;
    end
    // Post-write clock tracking; CKE must not fall inside it
    if (!(take && cmd.wr) && post_q != 2'h0) begin
      if (!cke_s) begin
        post_err_d = 1'b1;
        post_d = 2'h0;
      end else if (ck_rise) begin
        post_d = post_q - 2'h1;
      end
    end
    // Settling: both clock count and elapsed time must be met
    unique case (state_q)
      sem_pkg::SEM_IDLE: ;
      sem_pkg::SEM_SETTLE: begin
        if (ck_rise && nck_q != `SEM_SETTLE_NCK) nck_d = nck_q + 4'h1;
        if (ref_q != SETTLE_REF_CYC) ref_d = ref_q + 4'h1;
        if (nck_q == `SEM_SETTLE_NCK && ref_q == SETTLE_REF_CYC) begin
          state_d = sem_pkg::SEM_IDLE;
        end
      end
    endcase
  end

  // Reference selection and training pin masking
  always_comb begin
    ckref_d = act_q.single_ended_select_cfg[`SEM_BIT_SINGLE_CLOCK];
    dqsref_d = act_q.single_ended_select_cfg[`SEM_BIT_SINGLE_WRITE_STROBE];
    // DQ7, DQ15, DQ14, DMI1, DMI0, upper strobe pair
    ign_d = {6{cbt_s & (copy_q[0].single_ended_select_cfg[
      `SEM_BIT_SINGLE_WRITE_STROBE] != copy_q[1].single_ended_select_cfg[
      `SEM_BIT_SINGLE_WRITE_STROBE])}};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      copy_q[0] <= {9{`SEM_RST_CFG}};
      copy_q[1] <= {9{`SEM_RST_CFG}};
      ctrl_q <= 3'(`SEM_RST_CTRL);
      act_q <= {9{`SEM_RST_CFG}};
      state_q <= sem_pkg::SEM_IDLE;
      ck_prev_q <= 1'b0;
      nck_q <= 4'h0;
      ref_q <= 4'h0;
      post_q <= 2'h0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      early_q <= 1'b0;
      post_err_q <= 1'b0;
      ckref_q <= 1'b0;
      dqsref_q <= 1'b0;
      ign_q <= 6'h00;
    end else if (clk_en) begin
      copy_q <= copy_d;
      ctrl_q <= ctrl_d;
      act_q <= act_d;
      state_q <= state_d;
      ck_prev_q <= ck_prev_d;
      nck_q <= nck_d;
      ref_q <= ref_d;
      post_q <= post_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      early_q <= early_d;
      post_err_q <= post_err_d;
      ckref_q <= ckref_d;
      dqsref_q <= dqsref_d;
      ign_q <= ign_d;
    end
  end

  assign mrr_data = rdata_q;
  assign mrr_valid = rvalid_q;
  assign active_cfg = act_q;
  assign ctrl = ctrl_q;
  assign ck_ref_is_ca = ckref_q;
  assign dqs_ref_is_dq = dqsref_q;
  assign cbt_ignore_mask = ign_q;
  assign cmd_ready = (state_q == sem_pkg::SEM_IDLE);
  assign early_cmd_err = early_q;
  assign post_clk_err = post_err_q;
endmodule
`default_nettype wire

// ### logic/sem_map.svh
// Mode register addresses, field positions, reset values and timing figures
`ifndef SEM_MAP_SVH
`define SEM_MAP_SVH

// Mode register addresses
`define SEM_MA_PREAMBLE_RECOVERY 6'h01
`define SEM_MA_LATENCY 6'h02
`define SEM_MA_DRIVE_INVERSION 6'h03
`define SEM_MA_TERMINATION 6'h0B
`define SEM_MA_COMMAND_REFERENCE 6'h0C
`define SEM_MA_SET_POINT_CTRL 6'h0D
`define SEM_MA_DATA_REFERENCE 6'h0E
`define SEM_MA_LOW_SPEED_BUFFER 6'h15
`define SEM_MA_CONTROLLER_TERM 6'h16
`define SEM_MA_SINGLE_ENDED_SEL 6'h33

// Writable bits of each duplicated register
`define SEM_WMASK_PREAMBLE_RECOVERY 8'hFC
`define SEM_WMASK_LATENCY 8'h7F
`define SEM_WMASK_DRIVE_INVERSION 8'hFB
`define SEM_WMASK_TERMINATION 8'h77
`define SEM_WMASK_COMMAND_REFERENCE 8'h7F
`define SEM_WMASK_DATA_REFERENCE 8'h7F
`define SEM_WMASK_LOW_SPEED_BUFFER 8'h20
`define SEM_WMASK_CONTROLLER_TERM 8'h3F
`define SEM_WMASK_SINGLE_ENDED_SEL 8'h0E

// Set-point control register bits
`define SEM_BIT_FAST_RESPONSE 3
`define SEM_BIT_WRITE_SET_POINT 6
`define SEM_BIT_OPERATING_SET_POINT 7

// Single-ended select register bits
`define SEM_BIT_SINGLE_READ_STROBE 1
`define SEM_BIT_SINGLE_WRITE_STROBE 2
`define SEM_BIT_SINGLE_CLOCK 3

// Reset values
`define SEM_RST_CFG 8'h00
`define SEM_RST_CTRL 8'h00

// Timing
`define SEM_REF_PERIOD_PS 20000
`define SEM_SETTLE_TIME_PS 15000
`define SEM_SETTLE_NCK 4'h8
`define SEM_POST_WRITE_NCK 2'h2

`endif

// ### logic/sem_pkg.sv
// Types shared by the single-ended and set-point register set
package sem_pkg;

  // One physical copy of the duplicated mode registers
  typedef struct packed {
    logic [7:0] preamble_recovery_cfg;
    logic [7:0] latency_cfg;
    logic [7:0] drive_inversion_cfg;
    logic [7:0] termination_cfg;
    logic [7:0] command_reference_cfg;
    logic [7:0] data_reference_cfg;
    logic [7:0] low_speed_buffer_cfg;
    logic [7:0] controller_termination_cfg;
    logic [7:0] single_ended_select_cfg;
  } sem_cfg_t;

  // Set-point control register
  typedef struct packed {
    logic operating_set_point_sel;
    logic write_set_point_sel;
    logic reference_fast_response;
  } sem_ctrl_t;

  // Command captured at a link clock edge
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] op;
  } sem_cmd_t;

  // Link clock settling after a mode-changing set-point switch
  typedef enum logic [0:0] {
    SEM_IDLE = 1'b0,
    SEM_SETTLE = 1'b1
  } sem_state_t;

endpackage

// ### logic/sem_sync.sv
// Two-stage synchroniser for pins from outside the reference clock domain
`timescale 1ns/1ps
`default_nettype none
module sem_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### testbench/sem_ctl_model.sv
// Controller model driving the link pins of the register set
`timescale 1ns/1ps
`default_nettype none
module sem_ctl_model (
  // Clock
  input wire logic ref_clk,
  // Link pins
  output logic ck_pin,
  output logic cke_pin,
  output logic cs_pin,
  output logic mrw_pin,
  output logic mrr_pin,
  output logic [5:0] ma_pin,
  output logic [7:0] op_pin,
  output logic cbt_pin,
  // Read answer
  input wire logic mrr_valid,
  input wire logic [7:0] mrr_data
);
  logic got;
  logic [7:0] rdata;
  initial begin
    {ck_pin, cs_pin, mrw_pin, mrr_pin, cbt_pin} = 5'h00;
    cke_pin = 1'b1;
    ma_pin = 6'h00;
    op_pin = 8'h00;
    got = 1'b0;
    rdata = 8'h00;
  end
  // One CK period of 8 ref cycles; released lines show inverted values
  task automatic cyc(input logic c, input logic w, input logic [5:0] a,
      input logic [7:0] d);
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (i == 0) begin
        {cs_pin, mrw_pin, mrr_pin} = {c, c & w, c & !w};
        ma_pin = c ? a : ~ma_pin;
        op_pin = c ? d : ~op_pin;
      end
      ck_pin = (i >= 4);
      if (mrr_valid === 1'b1) begin
        got = 1'b1;
        rdata = mrr_data;
      end
    end
  endtask
  // Command, then n idle clocks; CK stands still afterwards
  task automatic cmd(input logic c, input logic w, input logic [5:0] a,
      input logic [7:0] d, input int n);
    got = 1'b0;
    cyc(c, w, a, d);
    repeat (n) cyc(1'b0, 1'b0, a, d);
    @(negedge ref_clk);
    ck_pin = 1'b0;
  endtask
  task automatic pins(input logic e, input logic t);
    @(negedge ref_clk);
    cke_pin = e;
    cbt_pin = t;
  endtask
endmodule
`default_nettype wire

// ### testbench/sem_regs_chk.sv
// Concurrent checks on the mode register set ports
`timescale 1ns/1ps
`default_nettype none
`include "sem_map.svh"
module sem_regs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Link pins
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic cs_pin,
  input wire logic mrw_pin,
  input wire logic mrr_pin,
  input wire logic [5:0] ma_pin,
  input wire logic [7:0] op_pin,
  input wire logic cbt_pin,
  // Outputs
  input wire logic [7:0] mrr_data,
  input wire logic mrr_valid,
  input wire sem_pkg::sem_cfg_t active_cfg,
  input wire sem_pkg::sem_ctrl_t ctrl,
  input wire logic ck_ref_is_ca,
  input wire logic dqs_ref_is_dq,
  input wire logic [5:0] cbt_ignore_mask,
  input wire logic cmd_ready,
  input wire logic early_cmd_err,
  input wire logic post_clk_err
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_valid_pulse: assert property (mrr_valid |=> !mrr_valid)
    else $error("read valid longer than one cycle");
  a_data_holds: assert property (!mrr_valid |-> $stable(mrr_data))
    else $error("read data moved without valid");
  a_valid_ready: assert property (mrr_valid |-> $past(cmd_ready))
    else $error("read answered while settling");
  a_early_sticky: assert property (early_cmd_err |=> early_cmd_err)
    else $error("early command flag cleared");
  a_post_sticky: assert property (post_clk_err |=> post_clk_err)
    else $error("post clock flag cleared");
  a_settle_min: assert property ($fell(cmd_ready) |-> !cmd_ready [*8])
    else $error("settling ended too soon");
  a_settle_ends: assert property ($fell(cmd_ready) |->
      ##[1:400] cmd_ready)
    else $error("settling never ended");
  // Reference flags follow the active copy one cycle later
  a_ck_ref_follow: assert property (ck_ref_is_ca == $past(
      active_cfg.single_ended_select_cfg[`SEM_BIT_SINGLE_CLOCK]))
    else $error("clock reference not from active copy");
  a_dqs_ref_follow: assert property (dqs_ref_is_dq == $past(
      active_cfg.single_ended_select_cfg[`SEM_BIT_SINGLE_WRITE_STROBE]))
    else $error("strobe reference not from active copy");
  a_mask_whole: assert property (
      cbt_ignore_mask inside {6'h00, 6'h3F})
    else $error("training mask partly set");
  a_ro_bits: assert property (
      (active_cfg.single_ended_select_cfg & ~`SEM_WMASK_SINGLE_ENDED_SEL) ==
      8'h00 && (active_cfg.low_speed_buffer_cfg &
      ~`SEM_WMASK_LOW_SPEED_BUFFER) == 8'h00)
    else $error("reserved bit set in active copy");
  c_read: cover property (mrr_valid);
  c_settle: cover property ($fell(cmd_ready));
  c_early: cover property ($rose(early_cmd_err));
  c_mask: cover property (cbt_ignore_mask != 6'h00);
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the duplicated mode register set
`timescale 1ns/1ps
`default_nettype none
`include "sem_map.svh"
module testbench;
  logic ref_clk, nrst, ck_pin, cke_pin, cs_pin, mrw_pin, mrr_pin, cbt_pin;
  logic mrr_valid, ck_ref_is_ca, dqs_ref_is_dq, cmd_ready, early_cmd_err;
  logic post_clk_err;
  logic clk_en = 1'b1;
  logic ws = 1'b0;
  logic os = 1'b0;
  logic [5:0] ma_pin, cbt_ignore_mask, a;
  logic [7:0] op_pin, mrr_data, d;
  sem_pkg::sem_cfg_t active_cfg;
  sem_pkg::sem_ctrl_t ctrl;
  logic [7:0] cp [2][64] = '{default: 8'h00};
  logic [5:0] mas [9] = '{6'h01, 6'h02, 6'h03, 6'h0B, 6'h0C, 6'h0E, 6'h15,
    6'h16, 6'h33};
  int err_count = 0;
  int checked = 0;
  int i, r;
  integer seed = 32'hb135c6b6;
  sem_regs dut_u (.ref_clk, .nrst, .clk_en, .ck_pin, .cke_pin, .cs_pin,
    .mrw_pin, .mrr_pin, .ma_pin, .op_pin, .cbt_pin, .mrr_data, .mrr_valid,
    .active_cfg, .ctrl, .ck_ref_is_ca, .dqs_ref_is_dq, .cbt_ignore_mask,
    .cmd_ready, .early_cmd_err, .post_clk_err);
  sem_ctl_model ctl_u (.ref_clk, .ck_pin, .cke_pin, .cs_pin, .mrw_pin,
    .mrr_pin, .ma_pin, .op_pin, .cbt_pin, .mrr_valid, .mrr_data);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] wm(input logic [5:0] x);
    case (x)
      `SEM_MA_PREAMBLE_RECOVERY: wm = `SEM_WMASK_PREAMBLE_RECOVERY;
      `SEM_MA_LATENCY: wm = `SEM_WMASK_LATENCY;
      `SEM_MA_DRIVE_INVERSION: wm = `SEM_WMASK_DRIVE_INVERSION;
      `SEM_MA_TERMINATION: wm = `SEM_WMASK_TERMINATION;
      `SEM_MA_COMMAND_REFERENCE: wm = `SEM_WMASK_COMMAND_REFERENCE;
      `SEM_MA_DATA_REFERENCE: wm = `SEM_WMASK_DATA_REFERENCE;
      `SEM_MA_LOW_SPEED_BUFFER: wm = `SEM_WMASK_LOW_SPEED_BUFFER;
      `SEM_MA_CONTROLLER_TERM: wm = `SEM_WMASK_CONTROLLER_TERM;
      `SEM_MA_SINGLE_ENDED_SEL: wm = `SEM_WMASK_SINGLE_ENDED_SEL;
      default: wm = 8'h00;
    endcase
  endfunction
  function automatic logic [71:0] ecfg(input logic s);
    logic [71:0] e;
    e = 72'h0;
    for (int k = 0; k < 9; k++) e = {e[63:0], cp[s][mas[k]]};
    return e;
  endfunction
  task automatic cmp(input logic [71:0] v, input logic [71:0] e);
    checked++;
    if (v !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, v, e);
    end
  endtask
  task automatic wr(input logic [5:0] x, input logic [7:0] v);
    ctl_u.cmd(1'b1, 1'b1, x, v, 2);
    if (x == 6'h0D) {os, ws} = v[7:6];
    cp[ws][x] = v & wm(x);
  endtask
  task automatic rd(input logic [5:0] x);
    ctl_u.cmd(1'b1, 1'b0, x, 8'h00, 2);
    cmp(72'({ctl_u.got, ctl_u.rdata}), 72'({1'b1, cp[ws][x]}));
  endtask
  task automatic give_verdict;
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (i = 0; i < 9; i++) rd(mas[i]);
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      a = r[20] ? mas[r[11:8] % 4'd9] : 6'h3E;
      d = r[7:0];
      if (a == 6'h33 && ws == os) d[3:2] = 2'b00;
      if (a == 6'h0C && d[5:0] > 6'h32) d[5:0] = 6'h32;
      if (a == 6'h03) d[0] = 1'b1;
      if (r[13:12] == 2'b00) wr(6'h0D, {1'b0, r[14], 6'h00});
      else if (r[15]) wr(a, d);
      else rd(a);
      cmp(active_cfg, ecfg(1'b0));
    end
    wr(6'h0D, 8'h40);
    wr(6'h33, 8'h0C);
    rd(6'h33);
    ctl_u.pins(1'b1, 1'b1);
    repeat (6) @(negedge ref_clk);
    cmp(72'(cbt_ignore_mask), 72'h3F);
    ctl_u.pins(1'b1, 1'b0);
    repeat (6) @(negedge ref_clk);
    cmp(72'(cbt_ignore_mask), 72'h00);
    wr(6'h0D, 8'hC8);
    cmp(72'({cmd_ready, ctrl}), 72'({1'b0, 3'b111}));
    ctl_u.cmd(1'b1, 1'b0, 6'h01, 8'h00, 1);
    cmp(72'({ctl_u.got, early_cmd_err}), 72'h1);
    ctl_u.cmd(1'b0, 1'b0, 6'h00, 8'h00, 8);
    cmp(72'({cmd_ready, ck_ref_is_ca, dqs_ref_is_dq, post_clk_err}),
      72'hE);
    cmp(active_cfg, ecfg(1'b1));
    ctl_u.cmd(1'b1, 1'b1, 6'h01, 8'h10, 0);
    ctl_u.pins(1'b0, 1'b0);
    repeat (6) @(negedge ref_clk);
    cmp(72'(post_clk_err), 72'h1);
    // Clock runs before power-down exit, then the write must read back
    ctl_u.cmd(1'b0, 1'b0, 6'h00, 8'h00, 1);
    ctl_u.pins(1'b1, 1'b0);
    cp[1][6'h01] = 8'h10;
    rd(6'h01);
    // Frozen block drops a set-point write
    clk_en = 1'b0;
    ctl_u.cmd(1'b1, 1'b1, 6'h0D, 8'h00, 2);
    clk_en = 1'b1;
    repeat (4) @(negedge ref_clk);
    cmp(72'({ctrl, cmd_ready}), 72'({3'b111, 1'b1}));
    give_verdict;
  end
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule
bind sem_regs sem_regs_chk chk_u (.ref_clk, .nrst, .clk_en, .ck_pin, .cke_pin,
  .cs_pin, .mrw_pin, .mrr_pin, .ma_pin, .op_pin, .cbt_pin, .mrr_data,
  .mrr_valid, .active_cfg, .ctrl, .ck_ref_is_ca, .dqs_ref_is_dq,
  .cbt_ignore_mask, .cmd_ready, .early_cmd_err, .post_clk_err);
`default_nettype wire
